// ===== tb/lat_host.sv
/*
  Host model issuing legacy I/O cycles to the trap unit, one cycle per call.
  Assumes the bench calls cycle() and the device samples on the rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module lat_host (
  // Clock
  input wire logic clock,
  // Legacy I/O cycles
  output var lat_pkg::lat_io_req_t io_req
);
  initial io_req = '0;
  // ----------------------------------------
  // One I/O cycle, then a released bus
  // ----------------------------------------
  task automatic cycle(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge clock);
    io_req <= '{valid: 1'b1, write: w, addr: a, data: d};
    @(negedge clock);
    io_req <= '{valid: 1'b0, write: ~w, addr: ~a, data: ~d};
  endtask
endmodule
`default_nettype wire

// ===== tb/test_lat_trap.sv
/*
  Self-checking bench for the trap unit: range traps, fast paths, status and enable registers.
  Assumes lat_host drives the I/O side and registers answer one cycle after a strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module test_lat_trap;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata_q;
  logic reg_ack_q;
  logic smi;
  logic io_fast_write;
  lat_pkg::lat_io_req_t io_req;
  lat_pkg::lat_io_rsp_t io_rsp;
  int mismatches = 0;
  int samples_checked = 0;
  logic [7:0] ev = 8'h00;
  logic [7:0] od = 8'h00;
  logic a1 = 1'b0;
  logic dir = 1'b0;
  logic [9:0] ad = 10'h000;
  lat_trap i_lat_trap (.clock(clock), .reset(reset), .clock_en(1'b1), .io_req(io_req),
    .io_rsp(io_rsp), .io_fast_write(io_fast_write), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_be(4'hf), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_ack_q(reg_ack_q), .smi(smi));
  lat_host i_lat_host (.clock(clock), .io_req(io_req));
  initial forever #5 clock = ~clock;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  function automatic logic [31:0] exp_st(input logic [3:0] fl);
    return {ev, od, a1, dir, fl, ad};
  endfunction
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    v = reg_rdata_q;
    `CHK(reg_ack_q, 1'b1)
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = {16'h0, d};
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    `CHK(reg_ack_q, 1'b1)
  endtask
  task automatic io(input logic w, input logic [9:0] a, input logic [7:0] d, input logic f);
    i_lat_host.cycle(w, a, d);
    if (w && (!f || a[0])) od = d;
    if (f && !a[0]) ev = d;
    if (f) a1 = a[1];
  endtask
  task automatic trap_case(input logic [15:0] en, input logic w, input logic [9:0] a,
                           input logic [3:0] fl);
    logic [31:0] v;
    wr(8'h18, en);
    io(w, a, a[7:0] ^ 8'ha5, 1'b0);
    if (fl != 4'h0) begin
      dir = w;
      ad = a;
    end
    `CHK(smi, |fl)
    rd(8'h14, v);
    `CHK(v, exp_st(fl))
    rd(8'h10, v);
    `CHK(v, {31'h0, |fl})
    rd(8'h14, v);
    `CHK(v, exp_st(4'h0))
    `CHK(smi, 1'b0)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] v;
    rd(8'h14, v);
    `CHK(v, 32'h0)
    wr(8'h18, 16'hffff);
    rd(8'h18, v);
    `CHK(v, 32'h0000_0fff)
    rd(8'h20, v);
    `CHK(v, 32'h0)
  endtask
  task automatic t_traps();
    trap_case(16'h0080, 1'b0, 10'h00f, 4'b0100);
    trap_case(16'h0080, 1'b0, 10'h010, 4'b0000);
    trap_case(16'h0100, 1'b1, 10'h0df, 4'b0100);
    trap_case(16'h0020, 1'b1, 10'h301, 4'b0010);
    trap_case(16'h0040, 1'b0, 10'h330, 4'b0010);
    trap_case(16'h0008, 1'b0, 10'h38b, 4'b0001);
    trap_case(16'h0004, 1'b1, 10'h22f, 4'b0001);
    trap_case(16'h0005, 1'b0, 10'h240, 4'b0001);
    trap_case(16'h0006, 1'b1, 10'h26a, 4'b0001);
    trap_case(16'h0007, 1'b1, 10'h26a, 4'b0000);
    trap_case(16'h0804, 1'b0, 10'h22c, 4'b1000);
    trap_case(16'h0000, 1'b1, 10'h0c0, 4'b0000);
  endtask
  task automatic t_fast_write();
    logic [31:0] v;
    wr(8'h18, 16'h0801);
    io(1'b1, 10'h248, 8'h33, 1'b1);
    `CHK(io_fast_write, 1'b1)
    `CHK(smi, 1'b0)
    rd(8'h14, v);
    `CHK(v, exp_st(4'h0))
    io(1'b1, 10'h38a, 8'h44, 1'b1);
    `CHK(io_fast_write, 1'b1)
    io(1'b1, 10'h38b, 8'h22, 1'b1);
    dir = 1'b1;
    ad = 10'h38b;
    `CHK(smi, 1'b1)
    rd(8'h14, v);
    `CHK(v, exp_st(4'b1000))
    rd(8'h12, v);
    `CHK(v, 32'h0000_0001)
    rd(8'h12, v);
    `CHK(v, 32'h0000_0001)
    rd(8'h10, v);
    `CHK(v, 32'h0000_0001)
    rd(8'h12, v);
    `CHK(v, 32'h0000_0000)
  endtask
  task automatic t_fast_read();
    wr(8'h18, 16'h0418);
    io(1'b0, 10'h389, 8'h00, 1'b0);
    `CHK(io_rsp.valid, 1'b1)
    `CHK(io_rsp.data, 8'h80)
    `CHK(smi, 1'b0)
    wr(8'h18, 16'h0410);
    io(1'b0, 10'h389, 8'h00, 1'b0);
    `CHK(io_rsp.valid, 1'b0)
    wr(8'h18, 16'h0615);
    io(1'b0, 10'h249, 8'h00, 1'b0);
    `CHK(io_rsp.data, 8'hc0)
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clock);
    reset = 1'b0;
    t_regs();
    t_traps();
    t_fast_write();
    t_fast_read();
    summarize();
  end
endmodule
`default_nettype wire

// ===== verilog/lat_match.sv
/*
  Address range matcher: compares an address with a base, ignoring LOW low bits.
  Assumes base has its low bits cleared.
*/
`timescale 1ns/1ps
`default_nettype none
module lat_match #(
  parameter int LOW = 4
) (
  // Compare inputs
  input wire logic [9:0] addr,
  input wire logic [9:0] base,
  // Result
  output logic hit
);
  assign hit = (addr[9:LOW] == base[9:LOW]);
endmodule
`default_nettype wire

// ===== verilog/lat_pkg.sv
/*
  Shared constants and types for the legacy audio I/O trap unit.
  Assumes a single clock domain and a host that issues one legacy I/O cycle at a time.
*/
`default_nettype none
package lat_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_SL_STATUS = 8'h10;
  localparam logic [7:0] OFF_SL_MIRROR = 8'h12;
  localparam logic [7:0] OFF_TRAP_STATUS = 8'h14;
  localparam logic [7:0] OFF_TRAP_ENABLE = 8'h18;
  localparam logic [31:0] TRAP_STATUS_RESET = 32'h0000_0000;
  localparam logic [15:0] TRAP_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] TRAP_ENABLE_MASK = 16'h0fff;
  // ----------------------------------------
  // Status fields
  // ----------------------------------------
  localparam int ST_EVEN_HI = 31;
  localparam int ST_EVEN_LO = 24;
  localparam int ST_ODD_HI = 23;
  localparam int ST_ODD_LO = 16;
  localparam int ST_A1 = 15;
  localparam int ST_DIR = 14;
  localparam int ST_SND_FW = 13;
  localparam int ST_DMA = 12;
  localparam int ST_MIDI = 11;
  localparam int ST_SND = 10;
  localparam int ST_ADDR_HI = 9;
  // ----------------------------------------
  // Enable fields
  // ----------------------------------------
  localparam int EN_FAST_WR = 11;
  localparam int EN_FAST_RD_HI = 10;
  localparam int EN_FAST_RD_LO = 9;
  localparam int EN_DMA_HI = 8;
  localparam int EN_DMA_LO = 7;
  localparam int EN_MIDI_HI = 6;
  localparam int EN_MIDI_LO = 5;
  localparam int EN_FAST_RD = 4;
  localparam int EN_SYNTH = 3;
  localparam int EN_SND = 2;
  localparam int EN_SEL_HI = 1;
  // ----------------------------------------
  // Port ranges
  // ----------------------------------------
  localparam logic [9:0] PORT_SYNTH = 10'h388;
  localparam logic [9:0] PORT_DMA_HI = 10'h0c0;
  localparam logic [9:0] PORT_DMA_LO = 10'h000;
  localparam logic [9:0] PORT_MIDI_HI = 10'h330;
  localparam logic [9:0] PORT_MIDI_LO = 10'h300;
  localparam logic [1:0] SEL_NONE = 2'h3;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] addr;
    logic [7:0] data;
  } lat_io_req_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } lat_io_rsp_t;
endpackage
`default_nettype wire

// ===== verilog/lat_trap.sv
/*
  Legacy audio I/O trap unit: range traps, fast write and fast read paths, status registers.
  Assumes one I/O request pulse per cycle at most and a simple register port at audio_register_base.
*/
// Functional notes
// - Even fast write data in bits 31:24
// - Odd fast or normal write data 23:16
// - Bit 15 holds A1 of fast write
// - Bit 14 holds last trap direction
// - Sound trap with fast write: bit 13
// - Sound trap without fast write: bit 10
// - DMA trap flags bit 12
// - MIDI trap flags bit 11
// - Bits 9:0 hold trapped address
// - Even fast write no interrupt; odd sets 13
// - Enable 11 answers fast writes directly
// - Enable 10:9 feeds fast read data
// - Enable 8 traps ports C0h-DFh
// - Enable 7 traps ports 00h-0Fh
// - Enable 6 traps ports 330h-331h
// - Enable 5 traps ports 300h-301h
// - Enable 4 answers fast reads directly
// - Enable 3 traps ports 388h-38Bh
// - Enable 2 traps selected sound range
// - Range select 00/01/10 gives 22x/24x/26x
// - Second level bit 0 summarises traps
`timescale 1ns/1ps
`default_nettype none
module lat_trap (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_en,
  // Legacy I/O cycles
  input wire lat_pkg::lat_io_req_t io_req,
  output lat_pkg::lat_io_rsp_t io_rsp,
  output logic io_fast_write,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [3:0] reg_be,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata_q,
  output logic reg_ack_q,
  // Interrupt
  output logic smi
);
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [31:0] st_q;
  logic [15:0] en_q;
  logic sl_q;
  logic [1:0] sel;
  logic [1:0] sel_p1;
  logic [9:0] snd_base;
  logic snd_m, synth_m, dma_hi_m, dma_lo_m, midi_hi_m, midi_lo_m;
  logic [3:0] lo;
  logic fw_addr, fr_addr, fast_wr, fast_rd, fw_even, fw_odd;
  logic snd_hit, dma_hit, midi_hit, trap;
  logic rd_status, rd_sl;

  localparam int EN_SEL_HI_L = lat_pkg::EN_SEL_HI;

  assign sel = en_q[EN_SEL_HI_L:0];
  assign sel_p1 = sel + 2'h1;
  assign snd_base = {2'h2, 1'b0, sel_p1, 1'b0, 4'h0};
  assign lo = io_req.addr[3:0];

  lat_match #(.LOW(4)) u_snd (.addr(io_req.addr), .base(snd_base), .hit(snd_m));
  lat_match #(.LOW(2)) u_synth (.addr(io_req.addr), .base(lat_pkg::PORT_SYNTH), .hit(synth_m));
  lat_match #(.LOW(5)) u_dma_hi (.addr(io_req.addr), .base(lat_pkg::PORT_DMA_HI), .hit(dma_hi_m));
  lat_match #(.LOW(4)) u_dma_lo (.addr(io_req.addr), .base(lat_pkg::PORT_DMA_LO), .hit(dma_lo_m));
  lat_match #(.LOW(1)) u_midi_hi (.addr(io_req.addr), .base(lat_pkg::PORT_MIDI_HI),
    .hit(midi_hi_m));
  lat_match #(.LOW(1)) u_midi_lo (.addr(io_req.addr), .base(lat_pkg::PORT_MIDI_LO),
    .hit(midi_lo_m));

  always_comb begin
    // Fast path ports; x of 2x0h comes from the selected range
    fw_addr = (synth_m && (lo[1:0] != 2'h1)) ||
      (snd_m && (sel != lat_pkg::SEL_NONE) && (lo == 4'h0 || lo == 4'h2 || lo == 4'h8));
    fr_addr = synth_m ||
      (snd_m && (sel != lat_pkg::SEL_NONE) && (lo[3:2] == 2'h0 || lo[3:1] == 3'h4));
  end

  assign fast_wr = io_req.valid && io_req.write && en_q[lat_pkg::EN_FAST_WR] && fw_addr;
  assign fast_rd = io_req.valid && !io_req.write && en_q[lat_pkg::EN_FAST_RD] && fr_addr &&
    (en_q[lat_pkg::EN_SND] || en_q[lat_pkg::EN_SYNTH]);
  assign fw_even = fast_wr && !io_req.addr[0];
  assign fw_odd = fast_wr && io_req.addr[0];
  assign snd_hit = io_req.valid && !fast_rd && !fw_even &&
    ((en_q[lat_pkg::EN_SND] && snd_m && (sel != lat_pkg::SEL_NONE)) ||
    (en_q[lat_pkg::EN_SYNTH] && synth_m));
  assign dma_hit = io_req.valid && ((en_q[lat_pkg::EN_DMA_HI] && dma_hi_m) ||
    (en_q[lat_pkg::EN_DMA_LO] && dma_lo_m));
  assign midi_hit = io_req.valid && ((en_q[lat_pkg::EN_MIDI_HI] && midi_hi_m) ||
    (en_q[lat_pkg::EN_MIDI_LO] && midi_lo_m));
  assign trap = snd_hit || dma_hit || midi_hit || fw_odd;

  assign rd_status = reg_rd && (reg_addr == lat_pkg::OFF_TRAP_STATUS);
  assign rd_sl = reg_rd && (reg_addr == lat_pkg::OFF_SL_STATUS);

  // ----------------------------------------
  // Data capture fields
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q <= lat_pkg::TRAP_STATUS_RESET;
    end else if (clock_en) begin
      if (fw_even) begin
        st_q[31:24] <= io_req.data;
      end
      if (fw_odd || (io_req.valid && io_req.write && !fast_wr)) begin
        st_q[23:16] <= io_req.data;
      end
      if (fast_wr) begin
        st_q[lat_pkg::ST_A1] <= io_req.addr[1];
      end
      if (trap) begin
        st_q[lat_pkg::ST_DIR] <= io_req.write;
        st_q[9:0] <= io_req.addr;
      end
      // Sticky trap flags, set wins over read clear
      st_q[lat_pkg::ST_SND_FW] <= (st_q[lat_pkg::ST_SND_FW] && !rd_status) || fw_odd ||
        (snd_hit && en_q[lat_pkg::EN_FAST_WR]);
      st_q[lat_pkg::ST_DMA] <= (st_q[lat_pkg::ST_DMA] && !rd_status) || dma_hit;
      st_q[lat_pkg::ST_MIDI] <= (st_q[lat_pkg::ST_MIDI] && !rd_status) || midi_hit;
      st_q[lat_pkg::ST_SND] <= (st_q[lat_pkg::ST_SND] && !rd_status) ||
        (snd_hit && !en_q[lat_pkg::EN_FAST_WR]);
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sl_q <= 1'b0;
    end else if (clock_en) begin
      sl_q <= (sl_q && !rd_sl) || trap;
    end
  end

  assign smi = |st_q[13:10];

  // ----------------------------------------
  // Enable register
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      en_q <= lat_pkg::TRAP_ENABLE_RESET;
    end else if (clock_en && reg_wr && reg_addr == lat_pkg::OFF_TRAP_ENABLE) begin
      if (reg_be[0]) begin
        en_q[7:0] <= reg_wdata[7:0];
      end
      if (reg_be[1]) begin
        en_q[15:8] <= reg_wdata[15:8] & lat_pkg::TRAP_ENABLE_MASK[15:8];
      end
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rdata_q <= 32'h0000_0000;
      reg_ack_q <= 1'b0;
    end else if (clock_en) begin
      reg_ack_q <= reg_rd || reg_wr;
      if (reg_rd) begin
        case (reg_addr)
          lat_pkg::OFF_SL_STATUS,
          lat_pkg::OFF_SL_MIRROR: begin
            reg_rdata_q <= {31'h0000_0000, sl_q};
          end
          lat_pkg::OFF_TRAP_STATUS: begin
            reg_rdata_q <= st_q;
          end
          lat_pkg::OFF_TRAP_ENABLE: begin
            reg_rdata_q <= {16'h0000, en_q};
          end
          default: begin
            reg_rdata_q <= 32'h0000_0000;
          end
        endcase
      end else begin
        reg_rdata_q <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Fast path answers
  // ----------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      io_rsp <= '0;
      io_fast_write <= 1'b0;
    end else if (clock_en) begin
      io_rsp.valid <= fast_rd;
      io_rsp.data <= fast_rd ? {en_q[lat_pkg::EN_FAST_RD_HI:lat_pkg::EN_FAST_RD_LO], 6'h00} :
        8'h00;
      io_fast_write <= fast_wr;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_even_data: assert property (@(posedge clock) disable iff (reset)
    clock_en && fw_even |=> st_q[31:24] == $past(io_req.data))
    else $error("even fast write data not captured");
  chk_odd_data: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && io_req.write && !fw_even |=> st_q[23:16] == $past(io_req.data))
    else $error("odd or normal write data not captured");
  chk_a1_bit: assert property (@(posedge clock) disable iff (reset)
    clock_en && fast_wr |=> st_q[lat_pkg::ST_A1] == $past(io_req.addr[1]))
    else $error("fast write A1 not recorded");
  chk_trap_dir: assert property (@(posedge clock) disable iff (reset)
    clock_en && trap |=> st_q[lat_pkg::ST_DIR] == $past(io_req.write) &&
    st_q[9:0] == $past(io_req.addr))
    else $error("trap direction or address wrong");
  chk_snd_fw: assert property (@(posedge clock) disable iff (reset)
    clock_en && snd_hit && en_q[lat_pkg::EN_FAST_WR] |=> st_q[13] && smi)
    else $error("sound trap with fast write not in bit 13");
  chk_snd_plain: assert property (@(posedge clock) disable iff (reset)
    clock_en && snd_hit && !en_q[lat_pkg::EN_FAST_WR] |=>
    st_q[10] && (st_q[13] == ($past(st_q[13]) && !$past(rd_status))))
    else $error("sound trap without fast write not in bit 10");
  chk_dma_flag: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && en_q[8] && io_req.addr >= 10'h0c0 && io_req.addr <= 10'h0df
    |=> st_q[lat_pkg::ST_DMA] ##1 (st_q[lat_pkg::ST_DMA] || $past(rd_status)))
    else $error("DMA trap not flagged");
  chk_midi_flag: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && en_q[6] && io_req.addr[9:1] == 9'h198 |=> st_q[lat_pkg::ST_MIDI])
    else $error("MIDI trap not flagged");
  chk_even_quiet: assert property (@(posedge clock) disable iff (reset)
    clock_en && fw_even && st_q[13:10] == 4'h0 && !rd_status |=> !smi)
    else $error("even fast write raised interrupt");
  chk_rd_clear: assert property (@(posedge clock) disable iff (reset)
    clock_en && rd_status && !io_req.valid |=> !smi)
    else $error("interrupt held after status read");
  chk_fast_read: assert property (@(posedge clock) disable iff (reset)
    clock_en && fast_rd |=> io_rsp.valid && io_rsp.data[7:6] == $past(en_q[10:9]) && !$rose(smi))
    else $error("fast read answer wrong");
  chk_sl_summary: assert property (@(posedge clock) disable iff (reset)
    clock_en && trap |=> sl_q)
    else $error("second level summary not set");
  chk_fast_wr_pulse: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && io_req.write && en_q[11] && (io_req.addr == 10'h388 ||
    io_req.addr == 10'h38a || io_req.addr == 10'h38b) |=> io_fast_write)
    else $error("fast write not answered");
  chk_no_fast_wr: assert property (@(posedge clock) disable iff (reset)
    clock_en && !(io_req.valid && io_req.write && en_q[11]) |=> !io_fast_write)
    else $error("fast write answered while not enabled");
  chk_dma_lo_flag: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && en_q[7] && io_req.addr <= 10'h00f |=> st_q[12])
    else $error("low DMA trap not flagged");
  chk_midi_lo_flag: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && en_q[5] && io_req.addr[9:1] == 9'h180 |=> st_q[11])
    else $error("low MIDI trap not flagged");
  chk_synth_flag: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && en_q[3] && !en_q[4] && !en_q[11] &&
    io_req.addr[9:2] == 8'he2 |=> st_q[10])
    else $error("synth port trap not flagged");
  chk_snd_range_lo: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && en_q[2] && !en_q[4] && !en_q[11] && en_q[1:0] == 2'h0 &&
    io_req.addr[9:4] == 6'h22 |=> st_q[10])
    else $error("sound range 22x not trapped");
  chk_snd_range_mid: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && en_q[2] && !en_q[4] && !en_q[11] && en_q[1:0] == 2'h1 &&
    io_req.addr[9:4] == 6'h24 |=> st_q[10])
    else $error("sound range 24x not trapped");
  chk_snd_range_hi: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && en_q[2] && !en_q[4] && !en_q[11] && en_q[1:0] == 2'h2 &&
    io_req.addr[9:4] == 6'h26 |=> st_q[10])
    else $error("sound range 26x not trapped");
  chk_fast_rd_quiet: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && !io_req.write && en_q[4] && en_q[3] &&
    io_req.addr[9:2] == 8'he2 |=> io_rsp.valid && !$rose(sl_q))
    else $error("fast read not answered quietly");
  chk_fast_rd_gate: assert property (@(posedge clock) disable iff (reset)
    clock_en && !en_q[2] && !en_q[3] |=> !io_rsp.valid)
    else $error("fast read answered without mapping");
  chk_fast_rd_x: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && !io_req.write && en_q[4] && en_q[2] && en_q[1:0] == 2'h1 &&
    io_req.addr == 10'h249 |=> io_rsp.valid)
    else $error("fast read x digit not from range");
  chk_fast_wr_x: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && io_req.write && en_q[11] && en_q[1:0] == 2'h2 &&
    io_req.addr == 10'h268 |=> io_fast_write)
    else $error("fast write x digit not from range");
  chk_sl_clear: assert property (@(posedge clock) disable iff (reset)
    clock_en && rd_sl && !io_req.valid |=> !sl_q)
    else $error("second level bit not cleared by read");
  chk_status_read: assert property (@(posedge clock) disable iff (reset)
    clock_en && rd_status |=> reg_ack_q && reg_rdata_q[9:0] == $past(st_q[9:0]))
    else $error("status read returned wrong address");
  chk_odd_fw_flag: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && io_req.write && en_q[11] && io_req.addr == 10'h38b
    |=> st_q[13] && smi && sl_q)
    else $error("odd fast write did not interrupt");
  chk_even_fw_hold: assert property (@(posedge clock) disable iff (reset)
    clock_en && io_req.valid && io_req.write && en_q[11] && io_req.addr == 10'h388 &&
    !rd_status |=> st_q[13:10] == $past(st_q[13:10]) && st_q[9:0] == $past(st_q[9:0]))
    else $error("even fast write changed trap state");
endmodule
`default_nettype wire
